// ---- design/sdi_interpolator.sv ----
// Stereo interpolator and noise shaper with its APB register file.
// Assumes pclk is the converter clock and the sample source runs on pclk.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "sdi_defs.svh"
module sdi_interpolator (
  input wire logic pclk, // Converter clock
  input wire logic presetn, // Asynchronous reset
  input wire logic [31:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic in_valid, // Stream FIFO has a sample pair
  input wire logic [23:0] in_left, // Left sample, left-justified
  input wire logic [23:0] in_right, // Right sample, left-justified
  output logic in_ready, // Input slot open this cycle; pair taken when in_valid is also high
  output logic [3:0] left_dac_code, // Left converter code
  output logic [3:0] right_dac_code, // Right converter code
  output logic audio_in_direction_select // Direction bit to the I2S input
);
  localparam logic [399:0] hb_tab = `SDI_HB_TAB;
  localparam logic [383:0] gain_tab = `SDI_GAIN_TAB;
  localparam logic [255:0] cos_tab = `SDI_COS_TAB;
  localparam logic [255:0] fir_sharp = `SDI_FIR_SHARP;
  localparam logic [255:0] fir_slow = `SDI_FIR_SLOW;
  localparam logic [63:0] emphasis_undo_select_beta = `SDI_EMPHASIS_UNDO_SELECT_BETA;

  logic [8:0] cfg_reg;
  logic [22:0] ctl_reg;
  logic [7:0] set_reg;
  logic [7:0] ph_reg;
  logic underrun_reg;
  sdi_pkg::sdi_ramp_type ramp_reg;
  logic [6:0] ramp_cnt_reg;
  sdi_pkg::sdi_sample_type lp_l_reg, lp_r_reg, hb_y_l_reg, hb_y_r_reg;
  sdi_pkg::sdi_sample_type hb_l_mem [0:49];
  sdi_pkg::sdi_sample_type hb_r_mem [0:49];
  sdi_pkg::sdi_sample_type fir_l_mem [0:7];
  sdi_pkg::sdi_sample_type fir_r_mem [0:7];
  logic [47:0] hb_acc_l_reg, hb_acc_r_reg, fir_acc_l_reg, fir_acc_r_reg;
  logic [4:0] hb_k_reg;
  logic hb_busy_reg, fir_busy_reg;
  logic [2:0] fir_j_reg;
  sdi_pkg::sdi_sample_type lin_l_reg, lin_r_reg, tgt_l_reg, tgt_r_reg, dlt_l_reg, dlt_r_reg;
  logic signed [26:0] el_reg [0:2];
  logic signed [26:0] er_reg [0:2];

  // Saturate a wide value to a sample
  function automatic sdi_pkg::sdi_sample_type sat24(input logic signed [47:0] v);
    if (v > 48'sh00_0000_7f_ffff) sat24 = 24'sh7f_ffff;
    else if (v < -48'sh00_0000_80_0000) sat24 = 24'sh80_0000;
    else sat24 = v[23:0];
  endfunction : sat24

  // Signed product widened for accumulation
  function automatic logic signed [47:0] term(input logic signed [24:0] a, input logic signed [15:0] c);
    term = 48'(a) * 48'(c);
  endfunction : term

  // Q15 scaling of a sample
  function automatic sdi_pkg::sdi_sample_type mulq(input logic signed [24:0] a, input logic signed [15:0] c);
    mulq = sat24(term(a, c) >>> 15);
  endfunction : mulq

  // Attenuation code to Q15 gain: 24 codes per halving up to code 0xc8, 8 codes per halving above it
  function automatic logic [15:0] att_gain(input logic [7:0] code);
    logic [8:0] eff;
    logic [4:0] idx;
    logic [3:0] sh;
    eff = (code <= 8'hc8) ? {1'b0, code} : 9'(9'h0c8 + 9'h003 * ({1'b0, code} - 9'h0c8));
    idx = 5'(eff % 9'h018);
    sh = 4'(eff / 9'h018);
    att_gain = (code[7:2] == 6'h3f) ? 16'h0000 : 16'(gain_tab[{idx, 4'h0} +: 16] >> sh);
  endfunction : att_gain

  // Symmetric 31-tap coefficient from the chosen set
  function automatic logic [15:0] fir_coef(input logic set1, input logic [4:0] n);
    logic [3:0] i;
    i = (n <= 5'h0f) ? n[3:0] : 4'(5'h1e - n);
    fir_coef = (n == 5'h1f) ? 16'h0000 : (set1 ? fir_slow[{i, 4'h0} +: 16] : fir_sharp[{i, 4'h0} +: 16]);
  endfunction : fir_coef

  // Sample width mask for 16 to 23 bit sources
  function automatic logic [23:0] width_mask(input logic [4:0] w);
    width_mask = (w >= 5'h10 && w < 5'h18) ? (24'hff_ffff << (5'h18 - w)) : 24'hff_ffff;
  endfunction : width_mask

  // One error-feedback step of the third-order shaper, returns code and error
  function automatic logic [30:0] shape(input logic signed [23:0] x, input logic signed [26:0] e1,
                                        input logic signed [26:0] e2, input logic signed [26:0] e3);
    logic signed [28:0] v;
    logic signed [8:0] q;
    v = 29'(x) + 29'sh3 * 29'(e1) - 29'sh3 * 29'(e2) + 29'(e3);
    q = 9'(v >>> 20);
    if (q > 9'sh007) q = 9'sh007;
    else if (q < 9'sh1f8) q = 9'sh1f8;
    shape = {q[3:0], 27'(v - (29'(q) <<< 20))};
  endfunction : shape

  // Stage timing from one phase counter
  wire ns256 = set_reg[`SDI_SET_NS256];
  wire rate2 = ctl_reg[`SDI_CTL_RATE] == 2'b01;
  wire [7:0] ph_last = ns256 ? 8'hff : 8'h7f;
  wire [7:0] ph_half = ns256 ? 8'h80 : 8'h40;
  wire [7:0] ph_next = (ph_reg >= ph_last) ? 8'h00 : 8'(ph_reg + 8'h01);
  wire [7:0] sub = ph_reg & (ns256 ? 8'h1f : 8'h0f);
  wire [1:0] fir_phase = ns256 ? ph_reg[6:5] : ph_reg[5:4];
  wire tick_fs = ph_reg == 8'h00;
  wire tick_2fs = tick_fs || ph_reg == ph_half;
  wire tick_8fs = sub == 8'h00;
  wire tick_128 = !ns256 || !ph_reg[0];
  wire ready_next = ph_next == 8'h00 || (rate2 && ph_next == ph_half);
  wire fir_push = ph_reg == 8'h01 || ph_reg == 8'(ph_half + 8'h01);
  wire fir_start = sub == 8'h02;

  // Input take, width mask and de-emphasis
  wire take = in_ready && in_valid;
  wire [23:0] wmask = width_mask(set_reg[`SDI_SET_WIDTH]);
  wire signed [23:0] x_l = take ? signed'(in_left & wmask) : 24'sh00_0000;
  wire signed [23:0] x_r = take ? signed'(in_right & wmask) : 24'sh00_0000;
  wire [2:0] dcode = ctl_reg[`SDI_CTL_EMPHASIS_UNDO_SELECT];
  wire emphasis_undo_select_on = !rate2 && dcode >= 3'h1 && dcode <= 3'h4;
  wire [15:0] beta = emphasis_undo_select_beta[{dcode[1:0] - 2'h1, 4'h0} +: 16];
  wire signed [24:0] dx_l = 25'(x_l) - 25'(lp_l_reg);
  wire signed [24:0] dx_r = 25'(x_r) - 25'(lp_r_reg);
  wire signed [23:0] de_l = emphasis_undo_select_on ? 24'(lp_l_reg + mulq(dx_l, `SDI_EMPHASIS_UNDO_SELECT_ALPHA)) : x_l;
  wire signed [23:0] de_r = emphasis_undo_select_on ? 24'(lp_r_reg + mulq(dx_r, `SDI_EMPHASIS_UNDO_SELECT_ALPHA)) : x_r;

  // Halfband pair sums and FIR tap selection
  wire [5:0] hb_lo = 6'(6'h18 - {1'b0, hb_k_reg});
  wire [5:0] hb_hi = 6'(6'h19 + {1'b0, hb_k_reg});
  wire signed [15:0] hb_c = hb_tab[{hb_k_reg, 4'h0} +: 16];
  wire signed [24:0] hb_p_l = 25'(hb_l_mem[hb_lo]) + 25'(hb_l_mem[hb_hi]);
  wire signed [24:0] hb_p_r = 25'(hb_r_mem[hb_lo]) + 25'(hb_r_mem[hb_hi]);
  wire signed [15:0] fir_c = fir_coef(ctl_reg[`SDI_CTL_COEF], {fir_j_reg, fir_phase});

  // Scaled FIR result and per-channel attenuation
  wire signed [15:0] att_r = att_gain(ctl_reg[`SDI_CTL_RATT]);
  wire signed [15:0] att_l = att_gain(ctl_reg[`SDI_CTL_LATT]);
  wire signed [23:0] fy_l = mulq(25'(sat24(fir_acc_l_reg >>> 15)), att_l);
  wire signed [23:0] fy_r = mulq(25'(sat24(fir_acc_r_reg >>> 15)), att_r);

  // Soft mute gain and polarity ahead of the shaper
  wire [15:0] ramp_gain = (ramp_reg == sdi_pkg::ramp_unmuted) ? 16'h7fff :
                          (ramp_reg == sdi_pkg::ramp_muted) ? 16'h0000 : cos_tab[{ramp_cnt_reg[6:3], 4'h0} +: 16];
  wire signed [23:0] m_l = mulq(25'(lin_l_reg), ramp_gain);
  wire signed [23:0] m_r = mulq(25'(lin_r_reg), ramp_gain);
  wire signed [23:0] ns_l = set_reg[`SDI_SET_LINV] ? 24'(-m_l) : m_l;
  wire signed [23:0] ns_r = set_reg[`SDI_SET_RINV] ? 24'(-m_r) : m_r;
  wire [30:0] sh_l = shape(ns_l, el_reg[0], el_reg[1], el_reg[2]);
  wire [30:0] sh_r = shape(ns_r, er_reg[0], er_reg[1], er_reg[2]);

  // APB decode and read mux
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite && pready;
  wire hit_cfg = paddr == `SDI_ADDR_STREAM_CFG;
  wire hit_ctl = paddr == `SDI_ADDR_CONTROL;
  wire hit_stat = paddr == `SDI_ADDR_STATUS;
  wire hit_set = paddr == `SDI_ADDR_SETTINGS;
  wire [2:0] stat = {ramp_reg == sdi_pkg::ramp_down || ramp_reg == sdi_pkg::ramp_up, underrun_reg,
                     ramp_reg == sdi_pkg::ramp_muted};
  wire [31:0] rd_data = hit_cfg ? {23'h00_0000, cfg_reg} : hit_ctl ? {9'h000, ctl_reg} :
                        hit_stat ? {29'h0000_0000, stat} : hit_set ? {24'h00_0000, set_reg} : 32'h0000_0000;

  // Register file writes and bus answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `SDI_STREAM_CFG_RST;
      ctl_reg <= `SDI_CONTROL_RST;
      set_reg <= `SDI_SETTINGS_RST;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b1;
    end else begin
      if (wr && hit_cfg) cfg_reg <= pwdata[8:0];
      if (wr && hit_ctl) ctl_reg <= pwdata[22:0];
      if (wr && hit_set) set_reg <= pwdata[7:0];
      prdata <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
      pslverr <= setup && !(hit_cfg || hit_ctl || hit_stat || hit_set);
      pready <= 1'b1;
    end
  end

  // Direction bit of the shared configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) audio_in_direction_select <= 1'b1;
    else audio_in_direction_select <= cfg_reg[`SDI_CFG_DIR];
  end

  // Phase counter, input slot and underrun level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg <= 8'h00;
      in_ready <= 1'b0;
      underrun_reg <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      in_ready <= ready_next;
      if (in_ready) underrun_reg <= !in_valid;
    end
  end

  // Input history, de-emphasis state and halfband output; cleared so no unknown enters the shaper loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 50; i++) begin
        hb_l_mem[i] <= 24'sh00_0000;
        hb_r_mem[i] <= 24'sh00_0000;
      end
      lp_l_reg <= 24'sh00_0000;
      lp_r_reg <= 24'sh00_0000;
      hb_y_l_reg <= 24'sh00_0000;
      hb_y_r_reg <= 24'sh00_0000;
    end else begin
      if (in_ready && !rate2) begin
        for (int i = 49; i > 0; i--) begin
          hb_l_mem[i] <= hb_l_mem[i-1];
          hb_r_mem[i] <= hb_r_mem[i-1];
        end
        hb_l_mem[0] <= de_l;
        hb_r_mem[0] <= de_r;
        lp_l_reg <= emphasis_undo_select_on ? 24'(lp_l_reg + mulq(dx_l, beta)) : x_l;
        lp_r_reg <= emphasis_undo_select_on ? 24'(lp_r_reg + mulq(dx_r, beta)) : x_r;
      end
      if (rate2 && in_ready) begin
        hb_y_l_reg <= x_l;
        hb_y_r_reg <= x_r;
      end else if (!rate2 && tick_fs) begin
        hb_y_l_reg <= hb_l_mem[24];
        hb_y_r_reg <= hb_r_mem[24];
      end else if (!rate2 && ph_reg == ph_half) begin
        hb_y_l_reg <= sat24(hb_acc_l_reg >>> 15);
        hb_y_r_reg <= sat24(hb_acc_r_reg >>> 15);
      end
    end
  end

  // Halfband odd-phase MAC, one pair per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_busy_reg <= 1'b0;
      hb_k_reg <= 5'h00;
      hb_acc_l_reg <= 48'h0000_0000_0000;
      hb_acc_r_reg <= 48'h0000_0000_0000;
    end else if (ph_reg == 8'h01) begin
      hb_busy_reg <= 1'b1;
      hb_k_reg <= 5'h00;
      hb_acc_l_reg <= 48'h0000_0000_0000;
      hb_acc_r_reg <= 48'h0000_0000_0000;
    end else if (hb_busy_reg) begin
      hb_acc_l_reg <= 48'(hb_acc_l_reg + term(hb_p_l, hb_c));
      hb_acc_r_reg <= 48'(hb_acc_r_reg + term(hb_p_r, hb_c));
      hb_k_reg <= 5'(hb_k_reg + 5'h01);
      hb_busy_reg <= hb_k_reg != `SDI_HB_LAST;
    end
  end

  // FIR history at 2 fs, cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        fir_l_mem[i] <= 24'sh00_0000;
        fir_r_mem[i] <= 24'sh00_0000;
      end
    end else if (fir_push) begin
      for (int i = 7; i > 0; i--) begin
        fir_l_mem[i] <= fir_l_mem[i-1];
        fir_r_mem[i] <= fir_r_mem[i-1];
      end
      fir_l_mem[0] <= hb_y_l_reg;
      fir_r_mem[0] <= hb_y_r_reg;
    end
  end

  // FIR polyphase MAC, eight taps per 8 fs output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fir_busy_reg <= 1'b0;
      fir_j_reg <= 3'h0;
      fir_acc_l_reg <= 48'h0000_0000_0000;
      fir_acc_r_reg <= 48'h0000_0000_0000;
    end else if (fir_start) begin
      fir_busy_reg <= 1'b1;
      fir_j_reg <= 3'h0;
      fir_acc_l_reg <= 48'h0000_0000_0000;
      fir_acc_r_reg <= 48'h0000_0000_0000;
    end else if (fir_busy_reg) begin
      fir_acc_l_reg <= 48'(fir_acc_l_reg + term(25'(fir_l_mem[fir_j_reg]), fir_c));
      fir_acc_r_reg <= 48'(fir_acc_r_reg + term(25'(fir_r_mem[fir_j_reg]), fir_c));
      fir_j_reg <= 3'(fir_j_reg + 3'h1);
      fir_busy_reg <= fir_j_reg != `SDI_FIR_LAST;
    end
  end

  // Linear interpolator, sixteen steps per 8 fs slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_l_reg <= 24'sh00_0000;
      lin_r_reg <= 24'sh00_0000;
      tgt_l_reg <= 24'sh00_0000;
      tgt_r_reg <= 24'sh00_0000;
      dlt_l_reg <= 24'sh00_0000;
      dlt_r_reg <= 24'sh00_0000;
    end else if (tick_8fs) begin
      lin_l_reg <= tgt_l_reg;
      lin_r_reg <= tgt_r_reg;
      tgt_l_reg <= fy_l;
      tgt_r_reg <= fy_r;
      dlt_l_reg <= 24'((25'(fy_l) - 25'(tgt_l_reg)) >>> 4);
      dlt_r_reg <= 24'((25'(fy_r) - 25'(tgt_r_reg)) >>> 4);
    end else if (tick_128) begin
      lin_l_reg <= 24'(lin_l_reg + dlt_l_reg);
      lin_r_reg <= 24'(lin_r_reg + dlt_r_reg);
    end
  end

  // Soft mute ramp, one step per fs period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_reg <= sdi_pkg::ramp_up;
      ramp_cnt_reg <= 7'h00;
    end else begin
      unique case (ramp_reg)
        sdi_pkg::ramp_unmuted: if (ctl_reg[`SDI_CTL_SOFT_SILENCE_BIT]) begin
          ramp_reg <= sdi_pkg::ramp_down;
          ramp_cnt_reg <= `SDI_RAMP_FS;
        end
        sdi_pkg::ramp_down: if (!ctl_reg[`SDI_CTL_SOFT_SILENCE_BIT]) ramp_reg <= sdi_pkg::ramp_up;
          else if (tick_fs && ramp_cnt_reg == 7'h00) ramp_reg <= sdi_pkg::ramp_muted;
          else if (tick_fs) ramp_cnt_reg <= 7'(ramp_cnt_reg - 7'h01);
        sdi_pkg::ramp_muted: if (!ctl_reg[`SDI_CTL_SOFT_SILENCE_BIT]) begin
          ramp_reg <= sdi_pkg::ramp_up;
          ramp_cnt_reg <= 7'h00;
        end
        sdi_pkg::ramp_up: if (ctl_reg[`SDI_CTL_SOFT_SILENCE_BIT]) ramp_reg <= sdi_pkg::ramp_down;
          else if (tick_fs && ramp_cnt_reg == `SDI_RAMP_FS) ramp_reg <= sdi_pkg::ramp_unmuted;
          else if (tick_fs) ramp_cnt_reg <= 7'(ramp_cnt_reg + 7'h01);
      endcase
    end
  end

  // Noise shaper every converter cycle, offset-binary codes out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        el_reg[i] <= 27'sh000_0000;
        er_reg[i] <= 27'sh000_0000;
      end
      left_dac_code <= 4'h8;
      right_dac_code <= 4'h8;
    end else begin
      el_reg[0] <= sh_l[26:0];
      el_reg[1] <= el_reg[0];
      el_reg[2] <= el_reg[1];
      er_reg[0] <= sh_r[26:0];
      er_reg[1] <= er_reg[0];
      er_reg[2] <= er_reg[1];
      left_dac_code <= sh_l[30:27] ^ 4'h8;
      right_dac_code <= sh_r[30:27] ^ 4'h8;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_slot_a: assert property (in_ready |-> (ph_reg == 8'h00 || (rate2 && ph_reg == ph_half)))
    else $error("ready outside input slot");
  ready_gap_a: assert property (in_ready && !rate2 |=> !in_ready [*8])
    else $error("input taken twice in one fs period");
  hb_mac_len_a: assert property ($rose(hb_busy_reg) |-> ##24 (hb_k_reg == 5'h18) ##1 !hb_busy_reg)
    else $error("halfband MAC length wrong");
  fir_mac_len_a: assert property ($rose(fir_busy_reg) |-> fir_busy_reg [*8] ##1 !fir_busy_reg)
    else $error("FIR MAC length wrong");
  bypass_take_a: assert property (rate2 && take |=> hb_y_l_reg == $past(x_l) && hb_y_r_reg == $past(x_r))
    else $error("2 fs input not bypassed");
  lin_start_a: assert property (tick_8fs |=> lin_l_reg == $past(tgt_l_reg) && lin_r_reg == $past(tgt_r_reg))
    else $error("interpolator not restarted at slot");
  mute_entry_a: assert property ($rose(ramp_reg == sdi_pkg::ramp_muted) |-> $past(ramp_cnt_reg) == 7'h00 &&
    $past(tick_fs) && ctl_reg[`SDI_CTL_SOFT_SILENCE_BIT])
    else $error("muted flag set early");
  ctl_write_a: assert property (wr && hit_ctl |=> ctl_reg == $past(pwdata[22:0]))
    else $error("control write lost");
  cfg_read_a: assert property (setup && !pwrite && hit_cfg |=> prdata == {23'h00_0000, $past(cfg_reg)})
    else $error("configuration read wrong");
  gain_mute_a: assert property (ctl_reg[7:2] == 6'h3f |-> att_r == 16'sh0000)
    else $error("mute code passes signal");
  status_read_a: assert property (setup && !pwrite && hit_stat |=> prdata[31:3] == 29'h0000_0000)
    else $error("status high bits set");
  take_cov: cover property (take && !rate2);
  bypass_cov: cover property (take && rate2);
  muted_cov: cover property ($rose(ramp_reg == sdi_pkg::ramp_muted));
  slow_set_cov: cover property (fir_busy_reg && ctl_reg[`SDI_CTL_COEF]);
endmodule : sdi_interpolator

// ---- shared/sdi_defs.svh ----
// Register map, field positions, reset values and filter tables of the stereo interpolator.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef SDI_DEFS_SVH
`define SDI_DEFS_SVH
// Byte addresses on the APB
`define SDI_ADDR_STREAM_CFG 32'h8020_0384
`define SDI_ADDR_CONTROL 32'h8020_0398
`define SDI_ADDR_STATUS 32'h8020_039c
`define SDI_ADDR_SETTINGS 32'h8020_03a0
// Reset values
`define SDI_STREAM_CFG_RST 9'h180
`define SDI_CONTROL_RST 23'h00_0000
`define SDI_SETTINGS_RST 8'h00
// Control fields
`define SDI_CTL_RATT 7:0
`define SDI_CTL_LATT 15:8
`define SDI_CTL_EMPHASIS_UNDO_SELECT 18:16
`define SDI_CTL_SOFT_SILENCE_BIT 19
`define SDI_CTL_RATE 21:20
`define SDI_CTL_COEF 22
// Settings fields
`define SDI_SET_NS256 0
`define SDI_SET_LINV 1
`define SDI_SET_RINV 2
`define SDI_SET_WIDTH 7:3
// Stream configuration and status fields
`define SDI_CFG_DIR 7
`define SDI_STAT_MUTED 0
`define SDI_STAT_UNDERRUN 1
`define SDI_STAT_RAMPING 2
// Timing in fs periods and filter sizes
`define SDI_RAMP_FS 7'h7f
`define SDI_HB_LAST 5'h18
`define SDI_FIR_LAST 3'h7
// Q15 tables, entry 0 in the low bits
`define SDI_HB_TAB {64'h000dffe5002effbc, 64'h005bff8a0098ff41, 64'h00eafee60153fe6e, 64'h01e5fdc402a3fcdf, \
  64'h03bcfb8c0565f955, 64'h086bf4d40ff8e51b, 16'h517c}
`define SDI_FIR_SHARP 256'h7fff72164f0a241c0000ec67ea8bf4260000074c07fc044b0000fdc8fde8ff28
`define SDI_FIR_SLOW 256'h7fff600040002000000000000000000000000000000000000000000000000000
`define SDI_GAIN_TAB {128'h41e043ce45cb47d649f14c1c4e5750a3, 128'h52ff556e57ef5a825d2a5fe462b46598, \
  128'h68926ba26ec972097560_78d17c5a7fff}
`define SDI_COS_TAB 256'h7fff7ec47b2075356d42638e587c4c7a400033852783_1c7112bd0aca04df013b
`define SDI_EMPHASIS_UNDO_SELECT_BETA 64'h1a3d2efa322d3f9e
`define SDI_EMPHASIS_UNDO_SELECT_ALPHA 16'h2872
`endif

// ---- shared/sdi_pkg.sv ----
// Types shared by the stereo interpolator design.
// Assumes nothing of its surroundings.
package sdi_pkg;
  typedef logic signed [23:0] sdi_sample_type;
  typedef enum logic [1:0] {ramp_unmuted, ramp_down, ramp_muted, ramp_up} sdi_ramp_type;
endpackage : sdi_pkg

// ---- tb/sdi_stream_source.sv ----
// Behavioural stream FIFO source for the interpolator's sample input.
// Assumes the design's clock; offers one steady pair while enabled.
`timescale 1ns/1ps
module sdi_stream_source (
  input wire logic pclk, // Clock
  input wire logic presetn, // Asynchronous reset
  input wire logic enable, // Source holds data
  input wire logic [23:0] level, // Sample value offered
  output logic in_valid, // Pair on offer
  output logic [23:0] in_left, // Left sample
  output logic [23:0] in_right // Right sample
);
  // Steady pair while enabled, changing pattern when released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_valid <= 1'b0;
      in_left <= ~level;
      in_right <= ~level;
    end else begin
      in_valid <= enable;
      in_left <= enable ? level : ~in_left;
      in_right <= enable ? level : ~in_right;
    end
  end
endmodule : sdi_stream_source

// ---- tb/test_sdi_interpolator.sv ----
// Self-checking bench for the stereo interpolator.
// Assumes the source model and the design are compiled first.
`timescale 1ns/1ps
`include "sdi_defs.svh"
module test_sdi_interpolator;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, src_en = 0, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, in_valid, in_ready, audio_in_direction_select;
  logic [23:0] in_left, in_right;
  logic [3:0] left_dac_code, right_dac_code;
  int fail_count = 0, n_compared = 0;
  // Clock, 40 ns period
  always #20 pclk = ~pclk;
  sdi_interpolator uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_left(in_left), .in_right(in_right), .in_ready(in_ready),
    .left_dac_code(left_dac_code), .right_dac_code(right_dac_code),
    .audio_in_direction_select(audio_in_direction_select));
  sdi_stream_source src (.pclk(pclk), .presetn(presetn), .enable(src_en), .level(24'h10_0000),
    .in_valid(in_valid), .in_left(in_left), .in_right(in_right));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; read data and error taken at the ready edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Edges between two sample slots
  task gap(input int exp);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (in_ready !== 1'b1 && n < 600);
    end
    chk(n, exp);
  endtask : gap
  task t_reset;
    apb(0, `SDI_ADDR_STREAM_CFG, 0);
    chk(rd[8:0], 32'h180);
    chk({31'h0, audio_in_direction_select}, 32'h1);
    apb(0, `SDI_ADDR_CONTROL, 0);
    chk(rd, 32'h0);
    apb(0, `SDI_ADDR_SETTINGS, 0);
    chk(rd, 32'h0);
    apb(0, `SDI_ADDR_STATUS, 0);
    chk(rd[1:0], 32'h0);
  endtask : t_reset
  task t_cfg;
    apb(1, `SDI_ADDR_STREAM_CFG, 32'h7f);
    apb(0, `SDI_ADDR_STREAM_CFG, 0);
    chk(rd[7:0], 32'h7f);
    chk({31'h0, audio_in_direction_select}, 32'h0);
    apb(1, `SDI_ADDR_STREAM_CFG, 32'hff);
    apb(0, `SDI_ADDR_STREAM_CFG + 32'h4, 0);
    chk({31'h0, err}, 32'h1);
    apb(1, `SDI_ADDR_STATUS, 32'hffff_ffff);
    apb(0, `SDI_ADDR_STATUS, 0);
    chk({31'h0, err}, 32'h0);
    chk(rd[0], 32'h0);
  endtask : t_cfg
  // Slot spacing for both rate modes and both shaper rates
  task t_rate;
    apb(1, `SDI_ADDR_CONTROL, 32'h0057_a55a);
    apb(0, `SDI_ADDR_CONTROL, 0);
    chk(rd, 32'h0057_a55a);
    gap(64);
    apb(1, `SDI_ADDR_CONTROL, 0);
    gap(128);
    apb(1, `SDI_ADDR_SETTINGS, 32'h1);
    gap(256);
    apb(1, `SDI_ADDR_SETTINGS, 0);
  endtask : t_rate
  task t_lock;
    int bad;
    bad = 0;
    src_en <= 1'b1;
    repeat (17920) @(posedge pclk);
    repeat (512) begin
      @(posedge pclk);
      if ($isunknown(left_dac_code) || left_dac_code !== right_dac_code) bad++;
    end
    chk(bad, 0);
    apb(0, `SDI_ADDR_STATUS, 0);
    chk(rd[1], 32'h0);
  endtask : t_lock
  task t_under;
    src_en <= 1'b0;
    repeat (300) @(posedge pclk);
    apb(0, `SDI_ADDR_STATUS, 0);
    chk(rd[1], 32'h1);
    src_en <= 1'b1;
    repeat (300) @(posedge pclk);
    apb(0, `SDI_ADDR_STATUS, 0);
    chk(rd[1], 32'h0);
  endtask : t_under
  task t_mute;
    int k, sum_l, sum_r;
    k = 0;
    sum_l = 0;
    sum_r = 0;
    apb(1, `SDI_ADDR_CONTROL, 32'h8_0000);
    do begin
      repeat (128) @(posedge pclk);
      k++;
      apb(0, `SDI_ADDR_STATUS, 0);
    end while (rd[0] !== 1'b1 && k < 200);
    chk({31'h0, k >= 120 && k <= 130}, 32'h1);
    // Muted shaper must average mid scale: code 8 per cycle, small residue
    repeat (256) begin
      @(posedge pclk);
      sum_l += left_dac_code;
      sum_r += right_dac_code;
    end
    chk({31'h0, sum_l >= 2044 && sum_l <= 2052}, 32'h1);
    chk({31'h0, sum_r >= 2044 && sum_r <= 2052}, 32'h1);
    apb(1, `SDI_ADDR_CONTROL, 0);
    repeat (256) @(posedge pclk);
    apb(0, `SDI_ADDR_STATUS, 0);
    chk(rd[2:0], 32'h4);
  endtask : t_mute
  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    #3_000_000;
    fail_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cfg();
    t_rate();
    t_lock();
    t_under();
    t_mute();
    complete_run();
  end
endmodule : test_sdi_interpolator
